// ===== shared/fpx_pkg.sv
// Purpose: constants and types shared by the floating-point exception block
// Assumes: one processor clock, asynchronous active-high reset
// Notes: flag groups ordered invalid, overflow, underflow, divzero, inexact
package fpx_pkg;
	localparam int CEXC_LSB = 0;
	localparam int AEXC_LSB = 5;
	localparam int QNE_BIT = 13;
	localparam int KIND_LSB = 14;
	localparam int MASK_LSB = 23;
	localparam int FLAG_W = 5;
	localparam int EXP_W = 12;
	localparam logic [63:0] STATE_RESET = 64'h0;
	localparam logic [63:0] LOAD_MASK = 64'h0000_0000_0F80_03FF;
	localparam int SGL_TINY = -25;
	localparam int DBL_TINY = -54;
	localparam int SGL_BIAS_M1 = 126;
	localparam int DBL_BIAS_M1 = 1022;
	localparam int SGL_DIV_LIM = 128;
	localparam int DBL_DIV_LIM = 1024;
	// Flag bit positions inside each five-bit group
	localparam int F_NV = 4;
	localparam int F_OF = 3;
	localparam int F_UF = 2;
	localparam int F_DZ = 1;
	localparam int F_NX = 0;
	typedef enum logic [2:0] {
		KIND_NONE = 3'h0,
		KIND_IEEE = 3'h1,
		KIND_INCOMPLETE = 3'h2,
		KIND_MISSING = 3'h3,
		KIND_SEQUENCE = 3'h4
	} trap_kind_t;
	typedef enum logic [2:0] {
		OP_ADD = 3'h0,
		OP_MUL = 3'h1,
		OP_DIV = 3'h2,
		OP_SQRT = 3'h3,
		OP_SMULD = 3'h4,
		OP_OTHER = 3'h5
	} op_class_t;
endpackage

// ===== shared/fpx_if.sv
// Purpose: operation descriptor passed to the incomplete-operation checker
// Assumes: same clock domain on both ends
// Notes: combinational carrier only
`timescale 1ns/100ps
`default_nettype none
interface fpx_if;
	import fpx_pkg::*;
	op_class_t op;
	logic dbl;
	logic den1;
	logic den2;
	logic nrm1;
	logic nrm2;
	logic pos1;
	logic [EXP_W-1:0] exp1;
	logic [EXP_W-1:0] exp2;
	logic signed [EXP_W+1:0] res_exp;
	logic uf_en;
	logic incomplete;
	modport top (output op, dbl, den1, den2, nrm1, nrm2, pos1, exp1, exp2,
		res_exp, uf_en, input incomplete);
	modport chk (input op, dbl, den1, den2, nrm1, nrm2, pos1, exp1, exp2,
		res_exp, uf_en, output incomplete);
endinterface
`default_nettype wire

// ===== src/fpx_incomplete_chk.sv
// Purpose: decides when an operation cannot finish in hardware
// Assumes: exponents are unnormalised biased values
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module fpx_incomplete_chk
	import fpx_pkg::*;
(
	// Operation descriptor
	fpx_if.chk d
);
	logic signed [EXP_W+2:0] e1;
	logic signed [EXP_W+2:0] e2;
	logic signed [EXP_W+2:0] tiny;
	logic signed [EXP_W+2:0] bias;
	logic signed [EXP_W+2:0] lim;
	logic one_den;
	logic both_nrm;
	logic res_tiny;

	////////////////////////////////////////////////////////////////////
	// Widened signed exponents so sums never wrap
	assign e1 = signed'({3'h0, d.exp1});
	assign e2 = signed'({3'h0, d.exp2});
	assign tiny = d.dbl ? (EXP_W+3)'(DBL_TINY) : (EXP_W+3)'(SGL_TINY);
	assign bias = d.dbl ? (EXP_W+3)'(DBL_BIAS_M1) : (EXP_W+3)'(SGL_BIAS_M1);
	assign lim = d.dbl ? (EXP_W+3)'(DBL_DIV_LIM) : (EXP_W+3)'(SGL_DIV_LIM);
	assign one_den = (d.den1 && d.nrm2) || (d.den2 && d.nrm1);
	assign both_nrm = d.nrm1 && d.nrm2;
	// Tiny check on the pre-rounding exponent, independent of enable
	assign res_tiny = (signed'(d.res_exp) > tiny) &&
		(signed'(d.res_exp) < (EXP_W+3)'(1));

	// Per-class decision
	always_comb begin
		d.incomplete = 1'b0;
		unique case (d.op)
			OP_MUL: begin
				if (one_den && (tiny < e1 + e2 - bias))
					d.incomplete = 1'b1;
				if (both_nrm && !d.uf_en && res_tiny)
					d.incomplete = 1'b1;
			end
			OP_SMULD: d.incomplete = d.den1 || d.den2;
			OP_DIV: begin
				if (d.den1 && d.den2)
					d.incomplete = 1'b1;
				if (d.nrm1 && d.den2 && (e1 - e2 - 1 < lim))
					d.incomplete = 1'b1;
				if (d.den1 && d.nrm2 && (e1 - e2 + bias > tiny))
					d.incomplete = 1'b1;
				if (both_nrm && !d.uf_en && res_tiny)
					d.incomplete = 1'b1;
			end
			OP_SQRT: d.incomplete = d.den1 && d.pos1;
			OP_ADD, OP_OTHER: d.incomplete = 1'b0;
			default: d.incomplete = 1'b0;
		endcase
	end
endmodule // fpx_incomplete_chk
`default_nettype wire

// ===== src/fpu_exception_status.sv
// Purpose: floating-point state register, exception flags and trap select
// Assumes: pipeline presents one operation result per op_valid pulse
// Notes: outputs registered; trap reported one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module fpu_exception_status
	import fpx_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Operation completion from the pipeline
	input wire logic op_valid,
	input wire logic [2:0] op_class,
	input wire logic op_dbl,
	input wire logic op_quad,
	input wire logic op_unimpl,
	input wire logic op_den1,
	input wire logic op_den2,
	input wire logic op_nrm1,
	input wire logic op_nrm2,
	input wire logic op_pos1,
	input wire logic [EXP_W-1:0] op_exp1,
	input wire logic [EXP_W-1:0] op_exp2,
	input wire logic signed [EXP_W+1:0] op_res_exp,
	// Raw IEEE conditions of the operation
	input wire logic raw_invalid,
	input wire logic raw_divzero,
	input wire logic raw_overflow,
	input wire logic raw_tiny,
	input wire logic raw_zero_exact,
	input wire logic raw_inexact,
	// State register access
	input wire logic load_valid,
	input wire logic load_wide,
	input wire logic [63:0] load_data,
	input wire logic store_done,
	input wire logic store_error,
	input wire logic queue_read,
	// Results
	output logic [63:0] state_rd,
	output logic trap_ieee,
	output logic trap_misc,
	output logic [2:0] trap_kind_out
);
	logic [FLAG_W-1:0] trap_mask;
	logic [FLAG_W-1:0] aexc;
	logic [FLAG_W-1:0] cexc;
	logic [2:0] kind;
	logic [FLAG_W-1:0] next_cexc;
	logic ieee_trap_now;
	logic uf_flag;
	logic ieee_path;
	fpx_if dsc ();

	////////////////////////////////////////////////////////////////////
	// Descriptor to the checker
	assign dsc.op = op_class_t'(op_class);
	assign dsc.dbl = op_dbl;
	assign dsc.den1 = op_den1;
	assign dsc.den2 = op_den2;
	assign dsc.nrm1 = op_nrm1;
	assign dsc.nrm2 = op_nrm2;
	assign dsc.pos1 = op_pos1;
	assign dsc.exp1 = op_exp1;
	assign dsc.exp2 = op_exp2;
	assign dsc.res_exp = op_res_exp;
	assign dsc.uf_en = trap_mask[F_UF];

	fpx_incomplete_chk u_chk (
		.d(dsc)
	);

	////////////////////////////////////////////////////////////////////
	// Underflow definition: never on exact zero; tiny alone when trapped
	assign uf_flag = raw_tiny && !raw_zero_exact &&
		(trap_mask[F_UF] || raw_inexact);

	// New current flags, reduced to one bit when the result traps
	always_comb begin
		next_cexc = '0;
		next_cexc[F_NV] = raw_invalid;
		next_cexc[F_DZ] = raw_divzero && !raw_invalid;
		next_cexc[F_NX] = raw_inexact || raw_overflow || uf_flag;
		next_cexc[F_OF] = raw_overflow;
		next_cexc[F_UF] = uf_flag;
		if (raw_overflow && trap_mask[F_OF]) begin
			next_cexc = '0;
			next_cexc[F_OF] = 1'b1;
		end else if (uf_flag && trap_mask[F_UF]) begin
			next_cexc = '0;
			next_cexc[F_UF] = 1'b1;
		end else if ((raw_overflow || uf_flag) && trap_mask[F_NX]) begin
			next_cexc = '0;
			next_cexc[F_NX] = 1'b1;
		end else if ((next_cexc & trap_mask) != '0) begin
			// Single trapping bit, highest priority first
			if (next_cexc[F_NV] && trap_mask[F_NV])
				next_cexc = 5'h10;
			else if (next_cexc[F_DZ] && trap_mask[F_DZ])
				next_cexc = 5'h02;
			else
				next_cexc = 5'h01;
		end
	end
	assign ieee_trap_now = (next_cexc & trap_mask) != '0;

	////////////////////////////////////////////////////////////////////
	// Trap select, current and accrued flags on completion
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cexc <= '0;
			aexc <= '0;
			kind <= KIND_NONE;
			trap_ieee <= 1'b0;
			trap_misc <= 1'b0;
		end else begin
			trap_ieee <= 1'b0;
			trap_misc <= 1'b0;
			if (queue_read) begin
				kind <= KIND_SEQUENCE;
				trap_misc <= 1'b1;
			end else if (op_valid) begin
				if (op_quad || op_unimpl) begin
					kind <= KIND_MISSING;
					trap_misc <= 1'b1;
				end else if (dsc.incomplete) begin
					kind <= KIND_INCOMPLETE;
					trap_misc <= 1'b1;
				end else if (ieee_trap_now) begin
					kind <= KIND_IEEE;
					cexc <= next_cexc;
					trap_ieee <= 1'b1;
				end else begin
					kind <= KIND_NONE;
					cexc <= next_cexc;
					aexc <= aexc | next_cexc;
				end
			end else if (load_valid) begin
				aexc <= load_data[AEXC_LSB +: FLAG_W];
				cexc <= load_data[CEXC_LSB +: FLAG_W];
			end else if (store_done && !store_error) begin
				kind <= KIND_NONE;
			end
		end
	end

	// Trap enable mask, written only by loads
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			trap_mask <= '0;
		else if (load_valid && !op_valid && !queue_read)
			trap_mask <= load_data[MASK_LSB +: FLAG_W];
	end

	// Registered read image; queue bit held zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_rd <= STATE_RESET;
			trap_kind_out <= KIND_NONE;
		end else begin
			state_rd <= STATE_RESET;
			state_rd[MASK_LSB +: FLAG_W] <= trap_mask;
			state_rd[KIND_LSB +: 3] <= kind;
			state_rd[QNE_BIT] <= 1'b0;
			state_rd[AEXC_LSB +: FLAG_W] <= aexc;
			state_rd[CEXC_LSB +: FLAG_W] <= cexc;
			trap_kind_out <= kind;
		end
	end

	// Operation that reaches the IEEE flag logic this cycle
	assign ieee_path = op_valid && !queue_read && !op_quad && !op_unimpl &&
		!dsc.incomplete;

	////////////////////////////////////////////////////////////////////
	// Assertions: trap select
	AST_QNE_ZERO: assert property (
		@(posedge clk_sys) disable iff (rst)
		state_rd[QNE_BIT] == 1'b0)
		else $error("queue bit not zero");
	AST_MISSING: assert property (
		@(posedge clk_sys) disable iff (rst)
		(op_valid && !queue_read && (op_quad || op_unimpl)) |=>
		(kind == KIND_MISSING) && trap_misc && $stable(cexc))
		else $error("missing op trap wrong");
	AST_UNIMPL_CEXC: assert property (
		@(posedge clk_sys) disable iff (rst)
		(op_valid && op_unimpl && !queue_read) |=> cexc == $past(cexc))
		else $error("cexc changed on missing op");
	AST_INCOMPLETE: assert property (
		@(posedge clk_sys) disable iff (rst)
		(op_valid && !queue_read && !op_quad && !op_unimpl && dsc.incomplete)
		|=> kind == KIND_INCOMPLETE && $stable(cexc))
		else $error("incomplete trap wrong");
	AST_SEQ: assert property (
		@(posedge clk_sys) disable iff (rst)
		queue_read |=> trap_misc && kind == KIND_SEQUENCE)
		else $error("queue read not trapped");
	AST_IEEE_ONEHOT: assert property (
		@(posedge clk_sys) disable iff (rst)
		trap_ieee |-> $onehot(cexc))
		else $error("ieee trap cexc not one-hot");
	AST_IEEE_AEXC: assert property (
		@(posedge clk_sys) disable iff (rst)
		trap_ieee |-> aexc == $past(aexc) && (cexc & trap_mask) != '0)
		else $error("aexc changed on ieee trap");
	AST_STORE_CLR: assert property (
		@(posedge clk_sys) disable iff (rst)
		(store_done && !store_error && !op_valid && !load_valid
		&& !queue_read) |=> kind == KIND_NONE ##1
		state_rd[KIND_LSB +: 3] == KIND_NONE)
		else $error("store did not clear kind");
	AST_STORE_ERR: assert property (
		@(posedge clk_sys) disable iff (rst)
		(store_done && store_error && !op_valid && !load_valid
		&& !queue_read) |=> $stable(kind))
		else $error("failed store changed kind");
	AST_NO_HW_ERR: assert property (
		@(posedge clk_sys) disable iff (rst)
		kind <= KIND_SEQUENCE)
		else $error("illegal trap kind");
	AST_TRAP_EXCL: assert property (
		@(posedge clk_sys) disable iff (rst)
		!(trap_ieee && trap_misc))
		else $error("two trap pulses at once");
	AST_IEEE_KIND: assert property (
		@(posedge clk_sys) disable iff (rst)
		trap_ieee |-> kind == KIND_IEEE)
		else $error("ieee trap with wrong kind");
	AST_KIND_OUT: assert property (
		@(posedge clk_sys) disable iff (rst)
		trap_kind_out == $past(kind))
		else $error("kind output not one cycle behind");
	AST_SQRT: assert property (
		@(posedge clk_sys) disable iff (rst)
		(op_valid && !queue_read && !op_quad && !op_unimpl &&
		dsc.op == OP_SQRT && op_den1 && op_pos1) |=> kind == KIND_INCOMPLETE)
		else $error("denormal root not incomplete");
	AST_SMULD: assert property (
		@(posedge clk_sys) disable iff (rst)
		(op_valid && !queue_read && !op_quad && !op_unimpl &&
		dsc.op == OP_SMULD && (op_den1 || op_den2)) |=>
		kind == KIND_INCOMPLETE)
		else $error("widening multiply not incomplete");
	AST_DIV_DEN: assert property (
		@(posedge clk_sys) disable iff (rst)
		(op_valid && !queue_read && !op_quad && !op_unimpl &&
		dsc.op == OP_DIV && op_den1 && op_den2) |=> kind == KIND_INCOMPLETE)
		else $error("denormal divide not incomplete");

	////////////////////////////////////////////////////////////////////
	// Assertions: overflow, underflow and divzero flag shaping
	AST_OF_NOTRAP: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && raw_overflow && !uf_flag && !raw_invalid &&
		!raw_divzero && !trap_mask[F_OF] && !trap_mask[F_NX]) |=>
		!trap_ieee && cexc[F_OF] && cexc[F_NX])
		else $error("overflow without enables wrong");
	AST_OF_NX: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && raw_overflow && !uf_flag && !trap_mask[F_OF] &&
		trap_mask[F_NX]) |=> trap_ieee && cexc == 5'h01)
		else $error("overflow inexact trap wrong");
	AST_OF_TRAP: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && raw_overflow && trap_mask[F_OF]) |=>
		trap_ieee && cexc == 5'h08)
		else $error("overflow trap wrong");
	AST_UF_NOTRAP: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && uf_flag && !raw_overflow && !raw_invalid &&
		!raw_divzero && !trap_mask[F_UF] && !trap_mask[F_NX]) |=>
		!trap_ieee && cexc[F_UF] && cexc[F_NX])
		else $error("underflow without enables wrong");
	AST_UF_NX: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && uf_flag && !raw_overflow && !trap_mask[F_UF] &&
		trap_mask[F_NX]) |=> trap_ieee && cexc == 5'h01)
		else $error("underflow inexact trap wrong");
	AST_UF_TRAP: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && uf_flag && !raw_overflow && trap_mask[F_UF]) |=>
		trap_ieee && cexc == 5'h04)
		else $error("underflow trap wrong");
	AST_UF_ZERO: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && raw_zero_exact) |=> !cexc[F_UF])
		else $error("underflow on exact zero");
	AST_DZ_INV: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && raw_invalid) |=> !cexc[F_DZ])
		else $error("divzero set with invalid");

	////////////////////////////////////////////////////////////////////
	// Assertions: accrual and loads
	AST_CEXC_CLR: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && !raw_invalid && !raw_divzero && !raw_overflow &&
		!raw_tiny && !raw_inexact) |=> cexc == '0)
		else $error("current flags not cleared");
	AST_ACCRUE: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ieee_path && !ieee_trap_now) |=>
		!trap_ieee && aexc == ($past(aexc) | cexc))
		else $error("accrued flags not merged");
	AST_LOAD_AEXC: assert property (
		@(posedge clk_sys) disable iff (rst)
		(load_valid && !op_valid && !queue_read) |=>
		aexc == $past(load_data[AEXC_LSB +: FLAG_W]))
		else $error("load did not write accrued flags");
	AST_LOAD_MASK: assert property (
		@(posedge clk_sys) disable iff (rst)
		(load_valid && !op_valid && !queue_read) |=>
		trap_mask == $past(load_data[MASK_LSB +: FLAG_W]))
		else $error("load did not write mask");
	AST_LOAD_KIND: assert property (
		@(posedge clk_sys) disable iff (rst)
		(load_valid && !op_valid && !queue_read) |=> $stable(kind))
		else $error("load changed trap kind");

	// Main scenarios reached
	COV_IEEE: cover property (@(posedge clk_sys) disable iff (rst) trap_ieee);
	COV_MISSING: cover property (@(posedge clk_sys) disable iff (rst)
		trap_misc && kind == KIND_MISSING);
	COV_INC: cover property (@(posedge clk_sys) disable iff (rst)
		kind == KIND_INCOMPLETE);
	COV_ACCRUE: cover property (@(posedge clk_sys) disable iff (rst)
		op_valid && !ieee_trap_now && next_cexc != '0);
	COV_STORE: cover property (@(posedge clk_sys) disable iff (rst)
		store_done && kind != KIND_NONE);
endmodule // fpu_exception_status
`default_nettype wire

// ===== verification/fpx_pipe_model.sv
// Purpose: pipeline side that issues one strobe and takes the traps
// Assumes: the bench sets one request code a cycle, at the falling edge
// Notes: trap pulses are counted on the rising edge, each one once
`timescale 1ns/100ps
`default_nettype none
module fpx_pipe_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Request code from the bench
	input wire logic [2:0] req,
	// Strobes to the block
	output logic op_valid,
	output logic load_valid,
	output logic store_done,
	output logic queue_read,
	// Traps from the block
	input wire logic trap_ieee,
	input wire logic trap_misc,
	output logic [15:0] ieee_cnt,
	output logic [15:0] misc_cnt
);
	// One code at a time, so no request is ever dropped by priority
	assign op_valid = req == 3'h1;
	assign load_valid = req == 3'h2;
	assign store_done = req == 3'h3;
	assign queue_read = req == 3'h4;

	// Trap intake; a stuck pulse shows up as an extra count
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ieee_cnt <= 16'h0;
			misc_cnt <= 16'h0;
		end else begin
			ieee_cnt <= ieee_cnt + 16'(trap_ieee);
			misc_cnt <= misc_cnt + 16'(trap_misc);
		end
	end
endmodule // fpx_pipe_model
`default_nettype wire

// ===== verification/fpu_exception_status_test.sv
// Purpose: random and boundary checks of the exception and status block
// Assumes: one request at a time, results read three cycles later
// Notes: boundary exponents are steered so off-by-one limits show up
`timescale 1ns/100ps
`default_nettype none
module fpu_exception_status_test;
	import fpx_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [2:0] op_class = 3'h0;
	logic op_dbl = 1'b0, op_quad = 1'b0, op_unimpl = 1'b0, op_pos1 = 1'b0;
	logic op_den1 = 1'b0, op_den2 = 1'b0, op_nrm1 = 1'b1, op_nrm2 = 1'b1;
	logic [EXP_W-1:0] op_exp1 = '0, op_exp2 = '0;
	logic signed [EXP_W+1:0] op_res_exp = '0;
	logic raw_invalid = 1'b0, raw_divzero = 1'b0, raw_overflow = 1'b0;
	logic raw_tiny = 1'b0, raw_zero_exact = 1'b0, raw_inexact = 1'b0;
	logic load_wide = 1'b0, store_error = 1'b0;
	logic [63:0] load_data = 64'h0;
	logic [2:0] req = 3'h0;
	logic op_valid, load_valid, store_done, queue_read;
	logic trap_ieee, trap_misc;
	logic [63:0] state_rd;
	logic [2:0] trap_kind_out;
	logic [15:0] ieee_cnt, misc_cnt, ni, nm;
	logic [4:0] m, a, c;
	logic [2:0] k;
	logic [31:0] r;
	int error_cnt = 0, samples_checked = 0, seed = 32'hc75b, cyc = 0;

	fpu_exception_status uut (.clk_sys, .rst, .op_valid, .op_class, .op_dbl,
		.op_quad, .op_unimpl, .op_den1, .op_den2, .op_nrm1, .op_nrm2,
		.op_pos1, .op_exp1, .op_exp2, .op_res_exp, .raw_invalid,
		.raw_divzero, .raw_overflow, .raw_tiny, .raw_zero_exact,
		.raw_inexact, .load_valid, .load_wide, .load_data, .store_done,
		.store_error, .queue_read, .state_rd, .trap_ieee, .trap_misc,
		.trap_kind_out);
	fpx_pipe_model pipe (.clk_sys, .rst, .req, .op_valid, .load_valid,
		.store_done, .queue_read, .trap_ieee, .trap_misc, .ieee_cnt,
		.misc_cnt);

	////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 12000) begin
			error_cnt = error_cnt + 1;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reporting
	task automatic chk(input string n, input logic [63:0] seen, exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic end_sim();
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One-cycle strobe, then let registered outputs settle
	task automatic send(input logic [2:0] code);
		@(negedge clk_sys) req = code;
		@(negedge clk_sys) req = 3'h0;
		repeat (3) @(negedge clk_sys);
	endtask

	task automatic check_all();
		chk("state", state_rd, {36'h0, m, 6'h0, k, 4'h0, a, c});
		chk("kind_out", {61'h0, trap_kind_out}, {61'h0, k});
		chk("ieee_traps", {48'h0, ieee_cnt}, {48'h0, ni});
		chk("misc_traps", {48'h0, misc_cnt}, {48'h0, nm});
	endtask

	////////////////////////////////////////////////////////////////////
	// Expectations; boundary operand exponent for the chosen operation
	function automatic logic [EXP_W-1:0] pick_exp(input logic den,
		input logic [31:0] v);
		int t, b, e;
		t = op_dbl ? DBL_TINY : SGL_TINY;
		b = op_dbl ? DBL_BIAS_M1 : SGL_BIAS_M1;
		e = op_class == 3'h1 ? t + b + 1 : op_den2 ?
			(op_dbl ? DBL_DIV_LIM : SGL_DIV_LIM) : b - t;
		e = e - 2 + int'(v % 5);
		return den ? '0 : EXP_W'(e);
	endfunction

	function automatic logic incomplete();
		int e1, e2, re, t, b;
		logic tn;
		e1 = op_exp1;
		e2 = op_exp2;
		re = op_res_exp;
		t = op_dbl ? DBL_TINY : SGL_TINY;
		b = op_dbl ? DBL_BIAS_M1 : SGL_BIAS_M1;
		tn = op_nrm1 && op_nrm2 && !m[2] && t < re && re < 1;
		case (op_class)
			3'h1: return (op_den1 ^ op_den2) ? t < e1 + e2 - b : tn;
			3'h2: return (op_den1 && op_den2) || tn || (op_den2 && !op_den1 &&
				e1 - e2 - 1 < (op_dbl ? DBL_DIV_LIM : SGL_DIV_LIM)) ||
				(op_den1 && !op_den2 && t < e1 - e2 + b);
			3'h3: return op_den1 && op_pos1;
			3'h4: return op_den1 || op_den2;
			default: return 1'b0;
		endcase
	endfunction

	function automatic void predict_op();
		logic [4:0] f;
		logic uf;
		uf = raw_tiny && !raw_zero_exact && (m[2] || raw_inexact);
		f = {raw_invalid, raw_overflow, uf, raw_divzero, raw_inexact};
		if (op_quad || op_unimpl) begin
			k = 3'h3;
			nm = nm + 16'h1;
		end else if (incomplete()) begin
			k = 3'h2;
			nm = nm + 16'h1;
		end else if ((f & m) == 5'h0) begin
			k = 3'h0;
			c = f;
			a = a | f;
		end else begin
			k = 3'h1;
			ni = ni + 16'h1;
			c = f[4] ? 5'h10 : f[1] ? 5'h02 : (f[3] && m[3]) ? 5'h08 :
				(f[2] && m[2]) ? 5'h04 : 5'h01;
		end
	endfunction

	task automatic rand_op();
		int t;
		r = $random(seed);
		op_class = r[2:0] % 3'h6;
		op_dbl = r[3];
		op_quad = r[7:4] == 4'h0;
		op_unimpl = r[11:8] == 4'h0;
		op_den1 = r[12] && op_class inside {3'h1, 3'h2, 3'h3, 3'h4};
		op_den2 = r[13] && op_class inside {3'h1, 3'h2, 3'h4};
		op_nrm1 = !op_den1;
		op_nrm2 = !op_den2;
		op_pos1 = r[14];
		op_exp1 = pick_exp(op_den1, r >> 15);
		op_exp2 = pick_exp(op_den2, r >> 19);
		t = op_dbl ? DBL_TINY : SGL_TINY;
		op_res_exp = 14'(r[28] ? t - 1 + int'(r[30:29]) : int'(r[30:29]) - 1);
		r = $random(seed);
		raw_invalid = r[2:0] == 3'h1;
		raw_divzero = r[2:0] == 3'h2;
		raw_overflow = r[2:0] == 3'h3;
		raw_tiny = r[2:0] == 3'h4;
		raw_zero_exact = raw_tiny && r[3];
		raw_inexact = raw_overflow || r[2:0] == 3'h5 || (raw_tiny && !r[3] && r[4]);
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence: reset image first, then mixed random traffic
	initial begin
		{ni, nm, m, a, c, k} = '0;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys) rst = 1'b0;
		check_all();
		for (int i = 0; i < 600; i++) begin
			r = $random(seed);
			case (r[2:0])
				3'h0: begin
					load_data = {$random(seed), $random(seed)};
					load_wide = r[3];
					m = load_data[27:23];
					a = load_data[9:5];
					c = load_data[4:0];
					send(3'h2);
				end
				3'h1: begin
					store_error = r[3];
					k = r[3] ? k : 3'h0;
					send(3'h3);
				end
				3'h2: begin
					k = 3'h4;
					nm = nm + 16'h1;
					send(3'h4);
				end
				default: begin
					rand_op();
					predict_op();
					send(3'h1);
				end
			endcase
			check_all();
		end
		// Mid-run reset clears every field, pulse and count
		@(negedge clk_sys) rst = 1'b1;
		{ni, nm, m, a, c, k} = '0;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		check_all();
		k = 3'h4;
		nm = 16'h1;
		send(3'h4);
		check_all();
		end_sim();
	end
endmodule // fpu_exception_status_test
`default_nettype wire
